// ==== pkg/lrs_pkg.sv ====
package lrs_pkg;
  // Device states as seen by the sampling logic
  typedef enum logic [1:0] {
    LRS_ST_RESET,
    LRS_ST_CONFIG,
    LRS_ST_NORMAL,
    LRS_ST_STANDBY
  } lrs_state_type;

  localparam int           LRS_CLK_MHZ           = 25;    // Core clock rate
  localparam int           LRS_DEGLITCH_NS       = 1000;  // Rate pin deglitch time
  localparam int           LRS_DEGLITCH_CYC      = (LRS_DEGLITCH_NS * LRS_CLK_MHZ + 999) / 1000;
  localparam int           LRS_WAKEUP_US         = 100;   // Wakeup interval
  localparam int           LRS_WAKEUP_CYC        = LRS_WAKEUP_US * LRS_CLK_MHZ;
  localparam int           LRS_POWERUP_US        = 200;   // First power-up interval
  localparam int           LRS_POWERUP_CYC       = LRS_POWERUP_US * LRS_CLK_MHZ;
  localparam logic         LRS_RATE_RESET        = 1'b0;  // Slow rate after reset
  localparam logic         LRS_RATE_FAST         = 1'b1;  // Pin level selecting fast
  localparam logic         LRS_ROLE_RESET        = 1'b0;  // Slave role after reset
  localparam int           LRS_CNT_W             = 16;    // Width of interval counters
endpackage : lrs_pkg

// ==== pkg/lrs_sync_if.sv ====
`timescale 1ns/100ps
// Synchronised and filtered pin levels from the front end
interface lrs_sync_if;
  logic rate_filt;   // Deglitched rate select
  logic cs_low_sync; // Synchronised chip select, high when asserted
  logic dis_sync;    // Synchronised disable pin
  logic role_sync;   // Synchronised role select
  modport front (output rate_filt, output cs_low_sync, output dis_sync, output role_sync);
  modport core  (input rate_filt, input cs_low_sync, input dis_sync, input role_sync);
endinterface : lrs_sync_if

// ==== rtl/lrs_pin_front.sv ====
`timescale 1ns/100ps
// Two-stage synchronisers plus deglitch filter for the rate pin
module lrs_pin_front #(
  parameter int DEGLITCH_CYC = lrs_pkg::LRS_DEGLITCH_CYC  // Stable cycles to accept
) (
  input  wire logic   core_clk,          // Core clock
  input  wire logic   reset,             // Synchronous reset
  input  wire logic   line_rate_select,  // Rate pin
  input  wire logic   chip_select_low,   // Chip select pin, active low
  input  wire logic   disable_wake_pin,  // Disable pin
  input  wire logic   role_select,       // Role pin
  lrs_sync_if.front   sync               // Cleaned levels
);
  import lrs_pkg::*;

  // Elaboration check: filter count must fit the 8-bit counter
  if (DEGLITCH_CYC < 1 || DEGLITCH_CYC > 255) begin : g_bad_deglitch
    $error("DEGLITCH_CYC out of range");
  end

  logic [3:0] s1_q, s1_d;   // First stages, read only by second
  logic [3:0] s2_q, s2_d;   // Second stages
  logic       filt_q, filt_d;   // Filtered rate level
  logic [7:0] cnt_q, cnt_d;     // Stability counter

  // Next values of synchronisers and filter
  always_comb begin
    s1_d   = {role_select, disable_wake_pin, chip_select_low, line_rate_select};
    s2_d   = s1_q;
    filt_d = filt_q;
    cnt_d  = cnt_q;
    if (s2_q[0] == filt_q) begin
      cnt_d = 8'h00;               // Agrees, restart count
    end else if (cnt_q == 8'(DEGLITCH_CYC - 1)) begin
      filt_d = s2_q[0];            // Stable long enough
      cnt_d  = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // Register stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_q   <= 4'h2;              // Chip select idles high
      s2_q   <= 4'h2;
      filt_q <= LRS_RATE_RESET;
      cnt_q  <= 8'h00;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      filt_q <= filt_d;
      cnt_q  <= cnt_d;
    end
  end

  assign sync.rate_filt   = filt_q;
  assign sync.cs_low_sync = !s2_q[1];  // Inverted after the second stage only
  assign sync.dis_sync    = s2_q[2];
  assign sync.role_sync   = s2_q[3];
endmodule : lrs_pin_front

// ==== rtl/lrs_rate_sampler.sv ====
`timescale 1ns/100ps
// Functional notes
// R01: Pin high selects fast, low selects slow
// R02: Slave normal: capture rate at chip select
// R03: Slave: receive rate applies right after capture
// R04: Slave: transmit rate waits for frame end
// R05: Idle transmitter takes latest capture, no pipelining; a slave capture reaches tx_fast one cycle after rx_fast
// R06: Master normal: track filtered pin continuously
// R07: Stand-by: capture rate during disable-falling wakeup
// R08: Host holds pin stable through wakeup
// R09: Reset: capture initial rate during first power-up
// R10: Host holds pin stable through power-up
// R11: Floating pin defaults to slow rate
// R12: Role latched once during configuration phase
// R13: Separate receive and transmit rate registers
module lrs_rate_sampler #(
  parameter int WAKEUP_CYC  = lrs_pkg::LRS_WAKEUP_CYC,   // Wakeup interval cycles
  parameter int POWERUP_CYC = lrs_pkg::LRS_POWERUP_CYC   // First power-up cycles
) (
  input  wire logic  core_clk,          // Core clock
  input  wire logic  reset,             // Synchronous reset, power-on
  input  wire logic  line_rate_select,  // Rate pin, pull-down assumed
  input  wire logic  chip_select_low,   // Chip select pin, active low
  input  wire logic  disable_wake_pin,  // Disable pin, high for stand-by
  input  wire logic  role_select,       // Role pin, high for master
  input  wire logic  tx_busy,           // Isolated transmitter sending a frame
  output logic       rx_fast,           // Receive path uses fast bit time
  output logic       tx_fast,           // Transmit path uses fast bit time
  output logic       role_master,       // Latched role, high for master
  output logic       normal_state       // Device in normal state
);
  import lrs_pkg::*;

  // Elaboration checks: intervals must fit the interval counter
  if (WAKEUP_CYC < 1 || WAKEUP_CYC >= (1 << LRS_CNT_W)) begin : g_bad_wakeup
    $error("WAKEUP_CYC out of range");
  end
  if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << LRS_CNT_W)) begin : g_bad_powerup
    $error("POWERUP_CYC out of range");
  end

  lrs_sync_if sync ();  // Cleaned pin levels

  // Pin front end
  lrs_pin_front u_front (
    .core_clk         (core_clk),
    .reset            (reset),
    .line_rate_select (line_rate_select),
    .chip_select_low  (chip_select_low),
    .disable_wake_pin (disable_wake_pin),
    .role_select      (role_select),
    .sync             (sync)
  );

  lrs_state_type        state_q, state_d;     // Device state
  logic [LRS_CNT_W-1:0] cnt_q, cnt_d;         // Interval counter
  logic                 role_q, role_d;       // Latched role
  logic                 rx_q, rx_d;           // Receive rate holding register
  logic                 tx_q, tx_d;           // Transmit rate holding register
  logic                 pend_q, pend_d;       // Latest captured rate for transmitter
  logic                 cs_q, cs_d;           // Previous chip select level
  logic                 dis_q, dis_d;         // Previous disable level
  logic                 cs_rise;              // Chip select assertion
  logic                 dis_fall;             // Disable falling edge
  logic                 is_fast;              // Pin level decoded

  // Decoding of the rate level into fast flag
  function automatic logic rate_is_fast(input logic lvl);
    return lvl == LRS_RATE_FAST;  // see R01
  endfunction : rate_is_fast

  assign cs_rise  = sync.cs_low_sync && !cs_q;
  assign dis_fall = !sync.dis_sync && dis_q;
  assign is_fast  = rate_is_fast(sync.rate_filt);

  // Next state, counters and rate registers
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    role_d  = role_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    pend_d  = pend_q;
    cs_d    = sync.cs_low_sync;
    dis_d   = sync.dis_sync;
    case (state_q)
      LRS_ST_RESET: begin
        // First power-up: pin sampled at end of interval
        if (cnt_q == LRS_CNT_W'(POWERUP_CYC - 1)) begin
          rx_d    = is_fast;              // see R09
          tx_d    = is_fast;              // see R09
          pend_d  = is_fast;
          role_d  = sync.role_sync;       // see R12
          cnt_d   = '0;
          state_d = LRS_ST_CONFIG;
        end else begin
          cnt_d = cnt_q + LRS_CNT_W'(1);
        end
      end
      LRS_ST_CONFIG: begin
        state_d = sync.dis_sync ? LRS_ST_STANDBY : LRS_ST_NORMAL;
      end
      LRS_ST_NORMAL: begin
        if (sync.dis_sync) begin
          state_d = LRS_ST_STANDBY;
        end else if (role_q) begin
          rx_d   = is_fast;               // see R06
          pend_d = is_fast;               // see R06
        end else if (cs_rise) begin
          rx_d   = is_fast;               // see R02, R03
          pend_d = is_fast;               // see R02, R05
        end
        if (!tx_busy) begin
          tx_d = (role_q || !cs_rise) ? pend_d : pend_q;  // see R04, R05, R13
        end
      end
      LRS_ST_STANDBY: begin
        // Wakeup: pin sampled at end of interval
        if (cnt_q != '0) begin
          if (cnt_q == LRS_CNT_W'(WAKEUP_CYC)) begin
            rx_d    = is_fast;            // see R07
            tx_d    = is_fast;            // see R07
            pend_d  = is_fast;
            cnt_d   = '0;
            state_d = LRS_ST_NORMAL;
          end else begin
            cnt_d = cnt_q + LRS_CNT_W'(1);
          end
        end else if (dis_fall) begin
          cnt_d = LRS_CNT_W'(1);
        end
      end
      default: begin
        state_d = LRS_ST_RESET;
        cnt_d   = '0;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= LRS_ST_RESET;
      cnt_q   <= '0;
      role_q  <= LRS_ROLE_RESET;
      rx_q    <= LRS_RATE_RESET;          // see R11
      tx_q    <= LRS_RATE_RESET;          // see R11
      pend_q  <= LRS_RATE_RESET;
      cs_q    <= 1'b0;
      dis_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      role_q  <= role_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      pend_q  <= pend_d;
      cs_q    <= cs_d;
      dis_q   <= dis_d;
    end
  end

  logic norm_q;  // Registered normal flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      norm_q <= 1'b0;
    end else begin
      norm_q <= (state_d == LRS_ST_NORMAL);
    end
  end

  assign rx_fast      = rx_q;
  assign tx_fast      = tx_q;
  assign role_master  = role_q;
  assign normal_state = norm_q;

  // Slave capture lands on receive rate next cycle
  property p_slave_rx_capture;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_NORMAL && !role_q && !sync.dis_sync && cs_rise)
      |=> (rx_q == $past(is_fast));
  endproperty
  a_slave_rx_capture: assert property (p_slave_rx_capture) else $error("rx missed"); // see R02

  // Slave receive rate stable without chip select edge
  property p_slave_rx_hold;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_NORMAL && !role_q && !cs_rise) |=> $stable(rx_q);
  endproperty
  a_slave_rx_hold: assert property (p_slave_rx_hold) else $error("rx tracked pin"); // see R02

  // Transmit rate frozen while a frame is sent
  property p_tx_frozen_busy;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_NORMAL && tx_busy) |=> $stable(tx_q);
  endproperty
  a_tx_frozen_busy: assert property (p_tx_frozen_busy) else $error("tx moved"); // see R04

  // Idle transmitter follows latest capture outside chip select edges
  property p_tx_latest;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_NORMAL && !tx_busy && !cs_rise) |=> (tx_q == $past(pend_d));
  endproperty
  a_tx_latest: assert property (p_tx_latest) else $error("tx not latest"); // see R05

  // Master tracks filtered pin
  property p_master_track;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_NORMAL && role_q && !sync.dis_sync) |=> (rx_q == $past(is_fast));
  endproperty
  a_master_track: assert property (p_master_track) else $error("master not tracking"); // see R06

  // Role never changes after configuration
  property p_role_fixed;
    @(posedge core_clk) disable iff (reset)
      (state_q != LRS_ST_RESET) |=> $stable(role_q);
  endproperty
  a_role_fixed: assert property (p_role_fixed) else $error("role changed"); // see R12

  // Stand-by rates held until wakeup completes
  property p_standby_hold;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_STANDBY && state_d == LRS_ST_STANDBY)
      |=> ($stable(rx_q) && $stable(tx_q));
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby rate moved"); // see R07

  // Rates slow after reset until power-up ends
  property p_reset_slow;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_RESET) |-> (!rx_q && !tx_q);
  endproperty
  a_reset_slow: assert property (p_reset_slow) else $error("rate not slow at reset"); // see R11

  // Rx and tx equal after power-up capture
  property p_powerup_capture;
    @(posedge core_clk) disable iff (reset)
      (state_q == LRS_ST_RESET && state_d == LRS_ST_CONFIG)
      |=> (rx_q == $past(is_fast) && tx_q == $past(is_fast));
  endproperty
  a_powerup_capture: assert property (p_powerup_capture) else $error("powerup capture"); // see R09
endmodule : lrs_rate_sampler

// ==== verif/lrs_host_model.sv ====
`timescale 1ns/100ps
// Host side of the pins; every pin move lands on a falling clock edge
module lrs_host_model (
  input  wire logic core_clk,          // Core clock
  output logic      line_rate_select,  // Rate pin as the device sees it
  output logic      chip_select_low,   // Chip select, low when asserted
  output logic      disable_wake_pin,  // High holds the device in stand-by
  output logic      role_select        // High selects master role
);
  logic rate_q;   // Level the host drives
  logic rate_en;  // Host drives the rate pin

  // Released pin sits on the board pull-down, so it reads slow
  assign line_rate_select = rate_en ? rate_q : 1'b0;

  // Idle pin levels from time zero
  initial begin
    rate_q           = 1'b0;
    rate_en          = 1'b1;
    chip_select_low  = 1'b1;
    disable_wake_pin = 1'b0;
    role_select      = 1'b0;
  end

  // Rate pin is only moved here and then held until the next call
  task automatic set_rate(input logic v, input logic en);
    @(negedge core_clk);
    rate_q  = v;
    rate_en = en;
  endtask : set_rate

  // Chip select level
  task automatic set_cs(input logic v);
    @(negedge core_clk);
    chip_select_low = v;
  endtask : set_cs

  // Disable pin; rate stays untouched across the wakeup
  task automatic set_dis(input logic v);
    @(negedge core_clk);
    disable_wake_pin = v;
  endtask : set_dis

  // Role pin level
  task automatic set_role(input logic v);
    @(negedge core_clk);
    role_select = v;
  endtask : set_role
endmodule : lrs_host_model

// ==== verif/tb_iso_line_rate_select_sampling.sv ====
`timescale 1ns/100ps
// Self-checking bench for the rate sampler with a host pin model
module tb_iso_line_rate_select_sampling;
  import lrs_pkg::*;
  localparam int WAKE_CYC = 40;  // Shortened wakeup interval
  localparam int PWR_CYC  = 40;  // Shortened power-up, longer than the filter
  localparam int SETTLE   = 32;  // Sync plus deglitch plus margin
  typedef struct packed {
    logic rate;    // Pin level for the frame
    logic busy;    // Transmitter busy at capture
    logic exp_tx;  // Transmit rate while busy holds
  } lrs_row_type;
  logic        core_clk;          // Core clock
  logic        reset;             // Synchronous reset
  logic        tx_busy;           // Transmitter sending
  wire         line_rate_select;  // Rate pin
  wire         chip_select_low;   // Chip select pin
  wire         disable_wake_pin;  // Disable pin
  wire         role_select;       // Role pin
  logic        rx_fast;           // Receive rate
  logic        tx_fast;           // Transmit rate
  logic        role_master;       // Latched role
  logic        normal_state;      // Normal state flag
  int          failures    = 0;   // Mismatch count
  int          checks_done = 0;   // Comparison count
  int          cycles      = 0;   // Cycles for the hang guard
  logic        prev;              // Last captured rate
  lrs_row_type rows [5]    = '{3'h0, 3'h6, 3'h0, 3'h5, 3'h3};  // Slave frames

  lrs_host_model host (.core_clk(core_clk), .line_rate_select(line_rate_select),
    .chip_select_low(chip_select_low), .disable_wake_pin(disable_wake_pin),
    .role_select(role_select));
  lrs_rate_sampler #(.WAKEUP_CYC(WAKE_CYC), .POWERUP_CYC(PWR_CYC)) dut (
    .core_clk(core_clk), .reset(reset), .line_rate_select(line_rate_select),
    .chip_select_low(chip_select_low), .disable_wake_pin(disable_wake_pin),
    .role_select(role_select), .tx_busy(tx_busy), .rx_fast(rx_fast), .tx_fast(tx_fast),
    .role_master(role_master), .normal_state(normal_state));

  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      give_verdict();
    end
  end

  // Compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Counts, then verdict, then stop
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Bounded wait for normal state
  task automatic wait_normal;
    int n;
    n = 0;
    while (normal_state !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    check(normal_state, 1'b1);
    @(negedge core_clk);
  endtask : wait_normal

  // Power-on reset asserted first, pins set during its two cycles
  task automatic do_reset(input logic role, input logic rate, input logic en);
    reset = 1'b1;
    host.set_role(role);
    host.set_rate(rate, en);
    check({rx_fast, tx_fast, role_master, normal_state}, 4'h0);
    reset = 1'b0;
    wait_normal();
  endtask : do_reset

  // One chip-select frame
  task automatic cs_frame;
    host.set_cs(1'b0);
    repeat (6) @(negedge core_clk);
    host.set_cs(1'b1);
    repeat (4) @(negedge core_clk);
  endtask : cs_frame

  // Settle a rate on the pin, then frame it
  task automatic frame(input logic v);
    host.set_rate(v, 1'b1);
    repeat (SETTLE) @(negedge core_clk);
    cs_frame();
  endtask : frame

  // Main sequence
  initial begin
    reset   = 1'b1;
    tx_busy = 1'b0;
    do_reset(1'b0, 1'b1, 1'b1);
    check({rx_fast, tx_fast, role_master}, 3'h6);
    $display("test powerup done");
    prev = 1'b1;
    foreach (rows[i]) begin
      @(negedge core_clk);
      tx_busy = rows[i].busy;
      host.set_rate(rows[i].rate, 1'b1);
      repeat (SETTLE) @(negedge core_clk);
      check(rx_fast, prev);
      cs_frame();
      check(rx_fast, rows[i].rate);
      check(tx_fast, rows[i].exp_tx);
      tx_busy = 1'b0;
      repeat (3) @(negedge core_clk);
      check(tx_fast, rows[i].rate);
      prev = rows[i].rate;
    end
    $display("test slave frames done");
    tx_busy = 1'b1;
    frame(1'b0);
    frame(1'b1);
    check(tx_fast, 1'b0);
    tx_busy = 1'b0;
    repeat (3) @(negedge core_clk);
    check(tx_fast, 1'b1);
    $display("test queued frames done");
    host.set_dis(1'b1);
    repeat (6) @(negedge core_clk);
    check(normal_state, 1'b0);
    frame(1'b0);
    check(rx_fast, 1'b1);
    host.set_dis(1'b0);
    wait_normal();
    check({rx_fast, tx_fast}, 2'h0);
    $display("test wakeup done");
    do_reset(1'b1, 1'b1, 1'b0);
    check({rx_fast, tx_fast, role_master}, 3'h1);
    host.set_role(1'b0);
    host.set_rate(1'b1, 1'b1);
    repeat (SETTLE) @(negedge core_clk);
    check({rx_fast, tx_fast, role_master}, 3'h7);
    host.set_rate(1'b0, 1'b1);
    repeat (5) @(negedge core_clk);
    check(rx_fast, 1'b1);
    host.set_rate(1'b1, 1'b1);
    repeat (SETTLE) @(negedge core_clk);
    check(rx_fast, 1'b1);
    $display("test master done");
    reset = 1'b1;
    host.set_dis(1'b1);
    host.set_rate(1'b0, 1'b1);
    reset = 1'b0;
    repeat (PWR_CYC + 8) @(negedge core_clk);
    check({rx_fast, tx_fast, role_master, normal_state}, 4'h0);
    host.set_rate(1'b1, 1'b1);
    repeat (SETTLE) @(negedge core_clk);
    check(rx_fast, 1'b0);
    host.set_dis(1'b0);
    wait_normal();
    check({rx_fast, tx_fast, role_master}, 3'h6);
    $display("test stand-by power-up done");
    give_verdict();
  end
endmodule : tb_iso_line_rate_select_sampling
